/* logic/coef_mem.sv */
// coefficient word store with registered read data
`timescale 1ns/100ps
`include "pressure_if_params.svh"

module coef_mem (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  wr_en,
	input  wire logic [`MEM_AW-1:0]    wr_addr,
	input  wire logic [15:0]           wr_data,
	input  wire logic                  rd_en,
	input  wire logic [`MEM_AW-1:0]    rd_addr,
	output logic      [15:0]           rd_data_r,
	output logic                       rd_valid_r
);

	logic [15:0] words [0:`MEM_WORDS-1];

	// factory load port, no reset on the array itself
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			words[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data_r  <= 16'h0000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
			if (rd_en) begin
				rd_data_r <= words[rd_addr];
			end
		end
	end

endmodule : coef_mem

/* logic/pressure_if_params.svh */
// constants of the pressure sensor command and readout interface
`ifndef PRESSURE_IF_PARAMS_SVH
`define PRESSURE_IF_PARAMS_SVH

// status byte bit positions
`define ST_ALU_ERR      0
`define ST_CONFIG       1
`define ST_NVM_ERR      2
`define ST_MODE_LO      3
`define ST_MODE_HI      4
`define ST_BUSY         5
`define ST_POWER        6
`define ST_ZERO         7
`define MODE_NORMAL     2'h0
`define STATUS_OK       8'h40

// command codes
`define CMD_SINGLE      8'hAA
`define CMD_AVG2        8'hAC
`define CMD_AVG4        8'hAD
`define CMD_AVG8        8'hAE
`define CMD_AVG16       8'hAF
`define CMD_READ        8'hF0
`define MEM_FIRST       8'h2F
`define MEM_LAST        8'h38

// link framing
`define I2C_ADDR        7'h28
`define BITS_PER_BYTE   4'h8
`define REC_LAST        3'h6
`define IDX_MAX         3'h7
`define SPI_CMD_LAST    3'h2

// coefficient store
`define MEM_WORDS       10
`define MEM_AW          4

`endif

/* logic/pressure_sensor_if.sv */
// command decoder, readout record and i2c/spi slave of the pressure sensor
// How it works
// [RULE1] readout: status, pressure msb-first, temperature msb-first
// [RULE2] memory readout: status, word high, word low
// [RULE3] error-free finished reading gives status 0x40
// [RULE4] status bit 6 shows power on
// [RULE5] status bit 5 is busy flag
// [RULE6] status bits 4:3 report mode, 00 normal
// [RULE7] status bit 2 flags memory checksum failure
// [RULE8] status bit 0 flags arithmetic unit error
// [RULE9] status bits 1 and 7 read zero
// [RULE10] core idles after power-up awaiting command
// [RULE11] measurement command: eoc low, busy, active
// [RULE12] finish: load results, eoc high, idle
// [RULE13] i2c seven-byte read returns whole record
// [RULE14] i2c host polls status until not busy
// [RULE15] i2c answers own 7-bit address, r/w bit
// [RULE16] spi host starts measurement with three bytes
// [RULE17] spi memory request returns status, two undefined
// [RULE18] spi 0xF0 returns status, idle or active
// [RULE19] spi host reads with 0xF0 plus six zeros
// [RULE20] host sends only defined command codes
// [RULE21] host waits before reading memory word
// [RULE22] host rebuilds coefficients from memory words
// [RULE23] start command: one byte i2c, three spi
// [RULE24] spi memory data read is three bytes
// [RULE25] averaging completes all conversions before update
`timescale 1ns/100ps
`include "pressure_if_params.svh"

module pressure_sensor_if (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	input  wire logic                cs_n_in,
	input  wire logic                sclk_in,
	input  wire logic                mosi_in,
	output logic                     miso_out,
	output logic                     miso_oe,
	output logic                     eoc_out,
	output logic                     conv_req,
	input  wire logic                conv_done,
	input  wire logic [23:0]         conv_press,
	input  wire logic [23:0]         conv_temp,
	input  wire logic                alu_err_in,
	input  wire logic                nvm_fail_in,
	input  wire logic                coef_wr_en,
	input  wire logic [`MEM_AW-1:0]  coef_wr_addr,
	input  wire logic [15:0]         coef_wr_data
);

	// pin synchronisers: scl, sda, cs_n, sclk, mosi
	logic [4:0] sync1_r, sync2_r, prev_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_r <= 5'h07; // pin idle levels, so no false edge after reset
			sync2_r <= 5'h07;
			prev_r  <= 5'h07;
		end else begin
			sync1_r <= {mosi_in, sclk_in, cs_n_in, sda_in, scl_in};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	wire scl_w      = sync2_r[0];
	wire sda_w      = sync2_r[1];
	wire cs_act_w   = ~sync2_r[2];
	wire mosi_w     = sync2_r[4];
	wire scl_rise_w = scl_w & ~prev_r[0];
	wire scl_fall_w = ~scl_w & prev_r[0];
	wire i2c_start  = scl_w & prev_r[0] & prev_r[1] & ~sda_w;
	wire i2c_stop   = scl_w & prev_r[0] & ~prev_r[1] & sda_w;
	wire cs_fall_w  = cs_act_w & prev_r[2];
	wire sclk_rise  = sync2_r[3] & ~prev_r[3];
	wire sclk_fall  = ~sync2_r[3] & prev_r[3];

	function automatic logic is_meas(input logic [7:0] c);
		is_meas = (c == `CMD_SINGLE) || (c == `CMD_AVG2) || (c == `CMD_AVG4) ||
			(c == `CMD_AVG8) || (c == `CMD_AVG16);
	endfunction : is_meas

	function automatic logic [2:0] avg_shift(input logic [7:0] c);
		case (c)
			`CMD_AVG2:  avg_shift = 3'h1;
			`CMD_AVG4:  avg_shift = 3'h2;
			`CMD_AVG8:  avg_shift = 3'h3;
			`CMD_AVG16: avg_shift = 3'h4;
			default:    avg_shift = 3'h0;
		endcase
	endfunction : avg_shift

	// core state
	pressure_types_pkg::core_state_t core_r;
	logic        busy_r, eoc_r, conv_req_r, alu_err_r, mem_mode_r, mem_rd_r;
	logic [2:0]  avg_sh_r;
	logic [4:0]  left_r;
	logic [27:0] sum_p_r, sum_t_r;
	logic [23:0] press_r, temp_r;
	logic [15:0] mem_word_r, mem_rdata;
	logic [`MEM_AW-1:0] mem_addr_r;
	logic        mem_vld;

	wire [7:0] status_w = {1'b0, 1'b1, busy_r, `MODE_NORMAL,
		nvm_fail_in, 1'b0, alu_err_r}; // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
	// record passed in whole, so callers in continuous assigns track every field
	wire [55:0] rec_w = {status_w, mem_mode_r ? mem_word_r : press_r[23:8],
		press_r[7:0], temp_r}; // [RULE1] [RULE2]

	function automatic logic [7:0] rec_byte(input logic [2:0] i, input logic [55:0] r);
		case (i)
			3'h0:    rec_byte = r[55:48];
			3'h1:    rec_byte = r[47:40];
			3'h2:    rec_byte = r[39:32];
			3'h3:    rec_byte = r[31:24];
			3'h4:    rec_byte = r[23:16];
			3'h5:    rec_byte = r[15:8];
			3'h6:    rec_byte = r[7:0];
			default: rec_byte = 8'h00;
		endcase
	endfunction : rec_byte

	// command strobes from either link
	logic       i2c_cmd_stb_r, spi_cmd_stb_r;
	logic [7:0] i2c_cmd_r, spi_first_r;
	wire        cmd_stb_w = i2c_cmd_stb_r | spi_cmd_stb_r;
	wire [7:0]  cmd_w     = i2c_cmd_stb_r ? i2c_cmd_r : spi_first_r;
	wire        is_mem_w  = (cmd_w >= `MEM_FIRST) && (cmd_w <= `MEM_LAST);
	wire [7:0]  mem_off_w = cmd_w - `MEM_FIRST;
	wire [27:0] sum_p_nxt = sum_p_r + {4'h0, conv_press};
	wire [27:0] sum_t_nxt = sum_t_r + {4'h0, conv_temp};
	wire [27:0] avg_p_w   = sum_p_nxt >> avg_sh_r;
	wire [27:0] avg_t_w   = sum_t_nxt >> avg_sh_r;

	coef_mem u_mem (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.wr_en      (coef_wr_en),
		.wr_addr    (coef_wr_addr),
		.wr_data    (coef_wr_data),
		.rd_en      (mem_rd_r),
		.rd_addr    (mem_addr_r),
		.rd_data_r  (mem_rdata),
		.rd_valid_r (mem_vld)
	);

	// commands arriving while busy are dropped; the host is meant to poll first
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_r     <= pressure_types_pkg::C_IDLE; // [RULE10]
			busy_r     <= 1'b0;
			eoc_r      <= 1'b1;
			conv_req_r <= 1'b0;
			alu_err_r  <= 1'b0;
			mem_mode_r <= 1'b0;
			mem_rd_r   <= 1'b0;
			mem_addr_r <= '0;
			avg_sh_r   <= 3'h0;
			left_r     <= 5'h00;
			sum_p_r    <= 28'h0000000;
			sum_t_r    <= 28'h0000000;
			press_r    <= 24'h000000;
			temp_r     <= 24'h000000;
			mem_word_r <= 16'h0000;
		end else begin
			conv_req_r <= 1'b0;
			mem_rd_r   <= 1'b0;
			case (core_r)
				pressure_types_pkg::C_IDLE: begin
					if (cmd_stb_w && is_meas(cmd_w)) begin
						core_r     <= pressure_types_pkg::C_CONV; // [RULE11]
						busy_r     <= 1'b1;
						eoc_r      <= 1'b0;
						conv_req_r <= 1'b1;
						alu_err_r  <= 1'b0;
						mem_mode_r <= 1'b0;
						avg_sh_r   <= avg_shift(cmd_w);
						left_r     <= 5'h01 << avg_shift(cmd_w);
						sum_p_r    <= 28'h0000000;
						sum_t_r    <= 28'h0000000;
					end else if (cmd_stb_w && is_mem_w) begin
						core_r     <= pressure_types_pkg::C_MEM;
						busy_r     <= 1'b1;
						mem_mode_r <= 1'b1;
						mem_rd_r   <= 1'b1;
						mem_addr_r <= mem_off_w[`MEM_AW-1:0];
					end
				end
				pressure_types_pkg::C_CONV: begin
					if (alu_err_in) begin
						alu_err_r <= 1'b1; // [RULE8]
					end
					if (conv_done) begin
						sum_p_r <= sum_p_nxt;
						sum_t_r <= sum_t_nxt;
						if (left_r == 5'h01) begin
							press_r <= avg_p_w[23:0]; // [RULE12]
							temp_r  <= avg_t_w[23:0];
							eoc_r   <= 1'b1;
							busy_r  <= 1'b0;
							core_r  <= pressure_types_pkg::C_IDLE;
						end else begin
							left_r     <= left_r - 5'h01; // [RULE25]
							conv_req_r <= 1'b1;
						end
					end
				end
				pressure_types_pkg::C_MEM: begin
					if (mem_vld) begin
						mem_word_r <= mem_rdata; // [RULE2]
						busy_r     <= 1'b0;
						core_r     <= pressure_types_pkg::C_IDLE;
					end
				end
				default: core_r <= pressure_types_pkg::C_IDLE;
			endcase
		end
	end

	// i2c slave, idle while the spi select is active
	pressure_types_pkg::i2c_state_t i2c_st_r;
	logic [3:0] i2c_cnt_r;
	logic [7:0] i2c_sh_r, i2c_tx_r;
	logic [2:0] i2c_idx_r;
	logic       i2c_rw_r, i2c_ack_r, sda_oe_r;
	wire  [7:0] i2c_byte_w = rec_byte(i2c_idx_r, rec_w);
	wire  [2:0] i2c_idx_nxt = (i2c_idx_r == `IDX_MAX) ? i2c_idx_r : i2c_idx_r + 3'h1;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			i2c_st_r      <= pressure_types_pkg::I_IDLE;
			i2c_cnt_r     <= 4'h0;
			i2c_sh_r      <= 8'h00;
			i2c_tx_r      <= 8'h00;
			i2c_idx_r     <= 3'h0;
			i2c_rw_r      <= 1'b0;
			i2c_ack_r     <= 1'b0;
			sda_oe_r      <= 1'b0;
			i2c_cmd_stb_r <= 1'b0;
			i2c_cmd_r     <= 8'h00;
		end else begin
			i2c_cmd_stb_r <= 1'b0;
			if (!cs_act_w && i2c_start) begin
				i2c_st_r  <= pressure_types_pkg::I_ADDR;
				i2c_cnt_r <= 4'h0;
				sda_oe_r  <= 1'b0;
			end else if (cs_act_w || i2c_stop) begin
				i2c_st_r <= pressure_types_pkg::I_IDLE;
				sda_oe_r <= 1'b0;
			end else begin
				case (i2c_st_r)
					pressure_types_pkg::I_IDLE: i2c_cnt_r <= 4'h0;
					pressure_types_pkg::I_ADDR: begin
						if (scl_rise_w) begin
							i2c_sh_r  <= {i2c_sh_r[6:0], sda_w};
							i2c_cnt_r <= i2c_cnt_r + 4'h1;
						end else if (scl_fall_w && i2c_cnt_r == `BITS_PER_BYTE) begin
							i2c_cnt_r <= 4'h0;
							if (i2c_sh_r[7:1] == `I2C_ADDR) begin
								sda_oe_r  <= 1'b1; // [RULE15]
								i2c_rw_r  <= i2c_sh_r[0];
								i2c_idx_r <= 3'h0;
								i2c_st_r  <= pressure_types_pkg::I_AACK;
							end else begin
								i2c_st_r <= pressure_types_pkg::I_IDLE;
							end
						end
					end
					pressure_types_pkg::I_AACK: begin
						if (scl_fall_w && i2c_rw_r) begin
							i2c_tx_r  <= i2c_byte_w; // [RULE13]
							sda_oe_r  <= ~i2c_byte_w[7];
							i2c_idx_r <= i2c_idx_nxt;
							i2c_st_r  <= pressure_types_pkg::I_TX;
						end else if (scl_fall_w) begin
							sda_oe_r <= 1'b0;
							i2c_st_r <= pressure_types_pkg::I_RX;
						end
					end
					pressure_types_pkg::I_RX: begin
						if (scl_rise_w) begin
							i2c_sh_r  <= {i2c_sh_r[6:0], sda_w};
							i2c_cnt_r <= i2c_cnt_r + 4'h1;
						end else if (scl_fall_w && i2c_cnt_r == `BITS_PER_BYTE) begin
							i2c_cnt_r <= 4'h0;
							sda_oe_r  <= 1'b1;
							i2c_st_r  <= pressure_types_pkg::I_RACK;
							i2c_idx_r <= 3'h1;
							if (i2c_idx_r == 3'h0) begin
								i2c_cmd_stb_r <= 1'b1; // [RULE23]
								i2c_cmd_r     <= i2c_sh_r;
							end
						end
					end
					pressure_types_pkg::I_RACK: begin
						if (scl_fall_w) begin
							sda_oe_r <= 1'b0;
							i2c_st_r <= pressure_types_pkg::I_RX;
						end
					end
					pressure_types_pkg::I_TX: begin
						if (scl_rise_w) begin
							i2c_tx_r  <= {i2c_tx_r[6:0], 1'b0};
							i2c_cnt_r <= i2c_cnt_r + 4'h1;
						end else if (scl_fall_w && i2c_cnt_r == `BITS_PER_BYTE) begin
							i2c_cnt_r <= 4'h0;
							sda_oe_r  <= 1'b0;
							i2c_st_r  <= pressure_types_pkg::I_TACK;
						end else if (scl_fall_w) begin
							sda_oe_r <= ~i2c_tx_r[7];
						end
					end
					pressure_types_pkg::I_TACK: begin
						if (scl_rise_w) begin
							i2c_ack_r <= ~sda_w;
						end else if (scl_fall_w && i2c_ack_r) begin
							i2c_tx_r  <= i2c_byte_w; // [RULE1]
							sda_oe_r  <= ~i2c_byte_w[7];
							i2c_idx_r <= i2c_idx_nxt;
							i2c_st_r  <= pressure_types_pkg::I_TX;
						end else if (scl_fall_w) begin
							i2c_st_r <= pressure_types_pkg::I_IDLE;
						end
					end
					default: i2c_st_r <= pressure_types_pkg::I_IDLE;
				endcase
			end
		end
	end

	// spi slave, mode 0; miso has about one and a half clk_sys of margin per half bit
	logic [2:0] spi_cnt_r, spi_idx_r;
	logic [7:0] spi_rx_r, spi_tx_r;
	logic       miso_r, miso_oe_r;
	wire  [7:0] spi_full_w = {spi_rx_r[6:0], mosi_w};
	wire  [2:0] spi_idx_nxt = (spi_idx_r == `IDX_MAX) ? spi_idx_r : spi_idx_r + 3'h1;
	wire  [7:0] spi_byte_w = (spi_idx_r == 3'h0) ? status_w :
		(spi_first_r == `CMD_READ) ? rec_byte(spi_idx_r, rec_w) : 8'h00; // [RULE17] [RULE24]

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			spi_cnt_r     <= 3'h0;
			spi_idx_r     <= 3'h0;
			spi_rx_r      <= 8'h00;
			spi_tx_r      <= 8'h00;
			spi_first_r   <= 8'h00;
			spi_cmd_stb_r <= 1'b0;
			miso_r        <= 1'b0;
			miso_oe_r     <= 1'b0;
		end else begin
			spi_cmd_stb_r <= 1'b0;
			if (!cs_act_w) begin
				spi_cnt_r <= 3'h0;
				spi_idx_r <= 3'h0;
				miso_oe_r <= 1'b0;
			end else if (cs_fall_w) begin
				spi_tx_r  <= status_w; // [RULE18]
				miso_r    <= status_w[7];
				miso_oe_r <= 1'b1;
			end else if (sclk_rise) begin
				spi_rx_r  <= spi_full_w;
				spi_cnt_r <= spi_cnt_r + 3'h1;
				if (spi_cnt_r == 3'h7) begin
					spi_idx_r <= spi_idx_nxt;
					if (spi_idx_r == 3'h0) begin
						spi_first_r <= spi_full_w;
					end
					if (spi_idx_r == `SPI_CMD_LAST && spi_first_r != `CMD_READ) begin
						spi_cmd_stb_r <= 1'b1; // [RULE23]
					end
				end
			end else if (sclk_fall && spi_cnt_r == 3'h0) begin
				spi_tx_r <= spi_byte_w; // [RULE1]
				miso_r   <= spi_byte_w[7];
			end else if (sclk_fall) begin
				spi_tx_r <= {spi_tx_r[6:0], 1'b0};
				miso_r   <= spi_tx_r[6];
			end
		end
	end

	assign sda_out  = 1'b0;
	assign sda_oe   = sda_oe_r;
	assign miso_out = miso_r;
	assign miso_oe  = miso_oe_r;
	assign eoc_out  = eoc_r;
	assign conv_req = conv_req_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_fixed_bits;
		status_w[`ST_ZERO] == 1'b0 && status_w[`ST_CONFIG] == 1'b0 && status_w[`ST_POWER]
			&& status_w[`ST_MODE_HI:`ST_MODE_LO] == `MODE_NORMAL;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("status fixed bits wrong"); // [RULE9]
	property p_busy_eoc;
		(core_r != pressure_types_pkg::C_MEM) |-> (status_w[`ST_BUSY] == ~eoc_r);
	endproperty
	a_busy_eoc: assert property (p_busy_eoc) else $error("busy and eoc disagree"); // [RULE5]
	property p_start;
		(core_r == pressure_types_pkg::C_IDLE && cmd_stb_w && is_meas(cmd_w))
			|=> (!eoc_r && busy_r && core_r == pressure_types_pkg::C_CONV ##1 !eoc_r);
	endproperty
	a_start: assert property (p_start) else $error("measurement start not taken"); // [RULE11]
	property p_finish;
		(core_r == pressure_types_pkg::C_CONV && conv_done && left_r == 5'h01)
			|=> (eoc_r && !busy_r && press_r == $past(avg_p_w[23:0]));
	endproperty
	a_finish: assert property (p_finish) else $error("finish not published"); // [RULE12]
	property p_avg;
		(conv_done && left_r > 5'h01 && core_r == pressure_types_pkg::C_CONV)
			|=> (busy_r && !eoc_r && conv_req_r);
	endproperty
	a_avg: assert property (p_avg) else $error("averaging ended early"); // [RULE25]
	property p_ok_status;
		(!busy_r && !alu_err_r && !nvm_fail_in) |-> (status_w == `STATUS_OK);
	endproperty
	a_ok_status: assert property (p_ok_status) else $error("clean status not 0x40"); // [RULE3]
	property p_nvm;
		status_w[`ST_NVM_ERR] == nvm_fail_in;
	endproperty
	a_nvm: assert property (p_nvm) else $error("checksum flag not shown"); // [RULE7]
	property p_alu;
		(core_r == pressure_types_pkg::C_CONV && alu_err_in) |=> status_w[`ST_ALU_ERR];
	endproperty
	a_alu: assert property (p_alu) else $error("alu error not flagged"); // [RULE8]
	property p_idle_ready;
		(core_r == pressure_types_pkg::C_IDLE) |-> !busy_r;
	endproperty
	a_idle_ready: assert property (p_idle_ready) else $error("idle core reports busy"); // [RULE10]
	property p_mem_rec;
		mem_mode_r |-> (rec_byte(3'h1, rec_w) == mem_word_r[15:8]
			&& rec_byte(3'h2, rec_w) == mem_word_r[7:0]);
	endproperty
	a_mem_rec: assert property (p_mem_rec) else $error("memory record order wrong"); // [RULE2]
	property p_spi_status;
		cs_fall_w |=> (miso_oe_r && miso_r == $past(status_w[7]));
	endproperty
	a_spi_status: assert property (p_spi_status) else $error("spi status bit missing"); // [RULE18]

	c_avg16: cover property (core_r == pressure_types_pkg::C_CONV && avg_sh_r == 3'h4
		&& conv_done && left_r == 5'h01);
	c_mem: cover property (core_r == pressure_types_pkg::C_MEM ##[1:4] mem_vld);
	c_i2c_tx: cover property (i2c_st_r == pressure_types_pkg::I_TX && i2c_idx_r == `IDX_MAX);
	c_spi_cmd: cover property (spi_cmd_stb_r);

endmodule : pressure_sensor_if

/* logic/pressure_types_pkg.sv */
// state types of the pressure sensor interface
package pressure_types_pkg;

	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_CONV = 3'b010,
		C_MEM  = 3'b100
	} core_state_t;

	typedef enum logic [6:0] {
		I_IDLE = 7'b0000001,
		I_ADDR = 7'b0000010,
		I_AACK = 7'b0000100,
		I_RX   = 7'b0001000,
		I_RACK = 7'b0010000,
		I_TX   = 7'b0100000,
		I_TACK = 7'b1000000
	} i2c_state_t;

endpackage : pressure_types_pkg

/* testbench/host_model.sv */
// host master model driving the i2c and spi pins of the sensor
`timescale 1ns/100ps

module host_model (
	input  wire logic clk_sys,
	input  wire logic sda_in,
	input  wire logic miso_in,
	output logic      scl,
	output logic      sda_low,
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi
);
	logic [7:0] rx [0:6];
	logic       ack;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		ack = 1'b0;
	end

	// mode 0: change while sclk low, sample on the rise
	task automatic spi_frame(input int n, input logic [7:0] b0);
		logic [7:0] tx;
		@(negedge clk_sys);
		cs_n = 1'b0;
		#400;
		for (int k = 0; k < n; k++) begin
			tx = (k == 0) ? b0 : 8'h00;
			for (int i = 7; i >= 0; i--) begin
				mosi = tx[i];
				#400 sclk = 1'b1;
				rx[k][i] = miso_in;
				#400 sclk = 1'b0;
			end
		end
		#400 cs_n = 1'b1;
		// deselected line must not look like a held bit
		mosi = ~mosi;
		#400;
	endtask : spi_frame

	// data set 100 ns after scl fall, well clear of the 2-flop sync skew
	task automatic i2c_bit(input logic b, output logic r);
		scl = 1'b0;
		#100 sda_low = ~b;
		#300 scl = 1'b1;
		#200 r = sda_in;
		#200;
	endtask : i2c_bit

	task automatic i2c_frame(input logic [6:0] adr, input logic rd, input int n,
		input logic [7:0] wb);
		logic [7:0] a;
		logic       r;
		@(negedge clk_sys);
		a = {adr, rd};
		sda_low = 1'b1;
		#400;
		for (int i = 7; i >= 0; i--) i2c_bit(a[i], r);
		i2c_bit(1'b1, r);
		ack = ~r;
		if (ack && !rd) begin
			for (int i = 7; i >= 0; i--) i2c_bit(wb[i], r);
			i2c_bit(1'b1, r);
		end
		for (int k = 0; ack && rd && k < n; k++) begin
			for (int i = 7; i >= 0; i--) i2c_bit(1'b1, rx[k][i]);
			i2c_bit(k == n - 1, r);
		end
		scl = 1'b0;
		#100 sda_low = 1'b1;
		#300 scl = 1'b1;
		#400 sda_low = 1'b0;
		#400;
	endtask : i2c_frame
endmodule : host_model

/* testbench/pressure_sensor_host_interface_tb.sv */
// self-checking bench of the sensor command and readout interface
`timescale 1ns/100ps
`include "pressure_if_params.svh"

module pressure_sensor_host_interface_tb;
	logic                clk_sys = 1'b0;
	logic                rst = 1'b1;
	logic                conv_done = 1'b0;
	logic [23:0]         conv_press = 24'h0;
	logic [23:0]         conv_temp = 24'h0;
	logic                alu_err_in = 1'b0;
	logic                nvm_fail_in = 1'b0;
	logic                coef_wr_en = 1'b0;
	logic [`MEM_AW-1:0]  coef_wr_addr = 4'h0;
	logic [15:0]         coef_wr_data = 16'h0;
	logic                scl, sda_low, cs_n, sclk, mosi;
	logic                sda_out, sda_oe, miso_out, miso_oe, eoc_out, conv_req;
	wire                 sda = ~((sda_oe & ~sda_out) | sda_low);
	// undriven miso shows the inverse, so a late drive cannot pass unseen
	wire                 miso_pin = miso_oe ? miso_out : ~miso_out;
	int                  err_count = 0;
	int                  cmp_count = 0;
	int                  seed = 68;
	int                  n_conv, pend = 0, alu_exp = 0, alu_arm = 0;
	longint              sum_p, sum_t;
	logic [15:0]         mem [0:9];

	always #50 clk_sys = ~clk_sys;

	pressure_sensor_if DUT (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .cs_n_in(cs_n), .sclk_in(sclk),
		.mosi_in(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .eoc_out(eoc_out),
		.conv_req(conv_req), .conv_done(conv_done), .conv_press(conv_press),
		.conv_temp(conv_temp), .alu_err_in(alu_err_in), .nvm_fail_in(nvm_fail_in),
		.coef_wr_en(coef_wr_en), .coef_wr_addr(coef_wr_addr), .coef_wr_data(coef_wr_data));

	host_model host (.clk_sys(clk_sys), .sda_in(sda), .miso_in(miso_pin), .scl(scl),
		.sda_low(sda_low), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

	// counting requests avoids missing a pulse reissued next to conv_done
	always @(posedge clk_sys) if (conv_req === 1'b1) pend++;

	// slow converter so busy can be seen from a status read
	always begin
		@(negedge clk_sys);
		if (pend > 0) begin
			pend--;
			repeat (60 + $unsigned($random(seed)) % 8) @(negedge clk_sys);
			conv_press = 24'($random(seed));
			conv_temp = 24'($random(seed));
			sum_p += conv_press;
			sum_t += conv_temp;
			n_conv++;
			conv_done = 1'b1;
			alu_err_in = alu_arm[0];
			@(negedge clk_sys);
			conv_done = 1'b0;
			alu_err_in = 1'b0;
		end
	end

	function automatic logic [7:0] stat(input int busy);
		return {2'b01, busy[0], 2'b00, nvm_fail_in, 1'b0, alu_exp[0]};
	endfunction : stat

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic wait_eoc;
		int i;
		for (i = 0; i < 3000 && eoc_out !== 1'b1; i++) @(negedge clk_sys);
		if (i == 3000) begin
			err_count++;
			$display("ERROR t=%0t eoc=%h exp=%h", $time, eoc_out, 1'b1);
			end_of_test;
		end
	endtask : wait_eoc

	task automatic measure(input logic [7:0] cmd, input int n, input logic i2c, input int alu);
		logic [55:0] rec;
		n_conv = 0;
		sum_p = 0;
		sum_t = 0;
		alu_exp = 0;
		alu_arm = alu;
		if (i2c) host.i2c_frame(`I2C_ADDR, 1'b0, 0, cmd);
		else host.spi_frame(3, cmd);
		@(negedge clk_sys);
		chk({7'h0, eoc_out}, 8'h00);
		if (!i2c) begin
			host.spi_frame(1, `CMD_READ);
			chk(host.rx[0], stat(1));
		end else begin
			chk({7'h0, host.ack}, 8'h01);
			for (int i = 0; i < 40; i++) begin
				host.i2c_frame(`I2C_ADDR, 1'b1, 1, 8'h00);
				if (host.rx[0][5] === 1'b0) break;
			end
			if (host.rx[0][5] !== 1'b0) begin
				err_count++;
				$display("ERROR t=%0t poll=%h exp=%h", $time, host.rx[0], 8'h40);
				end_of_test;
			end
		end
		wait_eoc;
		alu_exp = alu;
		chk(n_conv[7:0], n[7:0]);
		rec = {stat(0), 24'(sum_p / n), 24'(sum_t / n)};
		if (i2c) host.i2c_frame(`I2C_ADDR, 1'b1, 7, 8'h00);
		else host.spi_frame(7, `CMD_READ);
		for (int k = 0; k < 7; k++) chk(host.rx[k], rec[55-8*k -: 8]);
	endtask : measure

	task automatic mem_read(input int i, input logic i2c);
		logic [7:0] ad;
		ad = `MEM_FIRST + 8'(i);
		if (i2c) host.i2c_frame(`I2C_ADDR, 1'b0, 0, ad);
		else begin
			host.spi_frame(3, ad);
			chk(host.rx[0], stat(0));
		end
		repeat (20) @(negedge clk_sys);
		if (i2c) host.i2c_frame(`I2C_ADDR, 1'b1, 3, 8'h00);
		else host.spi_frame(3, `CMD_READ);
		chk(host.rx[0], stat(0));
		chk(host.rx[1], mem[i][15:8]);
		chk(host.rx[2], mem[i][7:0]);
	endtask : mem_read

	initial begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		for (int i = 0; i < `MEM_WORDS; i++) begin
			coef_wr_en = 1'b1;
			coef_wr_addr = 4'(i);
			coef_wr_data = 16'($random(seed));
			mem[i] = coef_wr_data;
			@(negedge clk_sys);
		end
		coef_wr_en = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk({4'h0, eoc_out, conv_req, sda_oe, miso_oe}, 8'h08);
		host.spi_frame(1, `CMD_READ);
		chk(host.rx[0], `STATUS_OK);
		measure(`CMD_SINGLE, 1, 1'b0, 0);
		measure(`CMD_AVG2, 2, 1'b1, 0);
		measure(`CMD_AVG4, 4, 1'b0, 1);
		measure(`CMD_AVG8, 8, 1'b0, 0);
		measure(`CMD_AVG16, 16, 1'b1, 0);
		nvm_fail_in = 1'b1;
		host.spi_frame(1, `CMD_READ);
		chk(host.rx[0], stat(0));
		nvm_fail_in = 1'b0;
		for (int i = 0; i < `MEM_WORDS; i++) mem_read(i, i[0]);
		host.i2c_frame(7'h29, 1'b1, 1, 8'h00);
		chk({7'h0, host.ack}, 8'h00);
		end_of_test;
	end
endmodule : pressure_sensor_host_interface_tb
